// [lpsc_defines.vh]
/*
 Constants for the laser power and eye-safety control block: register
 addresses, field positions and timing counts.
 Assumes inclusion by bare name from the design files.
*/
`ifndef LPSC_DEFINES_VH
`define LPSC_DEFINES_VH

// Register addresses on the serial port (7-bit)
`define LPSC_ADDR_CTRL_A 7'h1a
`define LPSC_ADDR_LEVEL 7'h1c
`define LPSC_ADDR_LEVEL_INV 7'h1d
`define LPSC_ADDR_CTRL_B 7'h1f

// Reset values of the four registers
`define LPSC_RST_CTRL_A 8'h40
`define LPSC_RST_LEVEL 8'h00
`define LPSC_RST_LEVEL_INV 8'hff
`define LPSC_RST_CTRL_B 8'h80

// Field positions
`define LPSC_CAL_HI 3
`define LPSC_CAL_LO 1
`define LPSC_CAL_ON 3'h7
// Range sits clear of the calibration bits so both can be set at once
`define LPSC_RANGE_HI 7
`define LPSC_RANGE_LO 6
`define LPSC_RINV_HI 7
`define LPSC_RINV_LO 6
`define LPSC_RANGE_LOW 2'h1
`define LPSC_RANGE_HIGH 2'h2

// Pulse timing in ns and derived cycles at 5 ns period
`define LPSC_CLK_NS 5
`define LPSC_PULSE_ON_NS 1000
`define LPSC_PULSE_PERIOD_NS 2000
`define LPSC_PULSE_ON_CYC (`LPSC_PULSE_ON_NS / `LPSC_CLK_NS)
`define LPSC_PULSE_PER_CYC (`LPSC_PULSE_PERIOD_NS / `LPSC_CLK_NS)

// Self-test timing: period, settle time of forced-low pin
`define LPSC_TEST_PERIOD_NS 20000
`define LPSC_TEST_SETTLE_NS 500
`define LPSC_TEST_PER_CYC (`LPSC_TEST_PERIOD_NS / `LPSC_CLK_NS)
`define LPSC_TEST_SETTLE_CYC (`LPSC_TEST_SETTLE_NS / `LPSC_CLK_NS)

// Run cycles after a self-test or reset before the ground check resumes
`define LPSC_PIN_GUARD_CYC 2

`endif

// [lpsc_spi_slave.v]
/*
 Four-wire serial slave for the laser register file. Sixteen-bit frames,
 MSB first: bit 15 high means write, bits 14..8 address, bits 7..0 data.
 On a read the data byte is shifted out on miso during the second byte.
 Assumes sclk, mosi and cs_n are asynchronous pins; all are resynchronised
 to clk_sys, so sclk must stay well below clk_sys/8.
*/
`timescale 1ns/100ps
`default_nettype none
module lpsc_spi_slave (
  input wire clk_sys,
  input wire rst_n,
  input wire sclk,
  input wire mosi,
  input wire cs_n,
  output reg miso,
  output reg miso_oe_n,
  output reg wr_stb,
  output reg [6:0] addr,
  output reg [7:0] wdata,
  input wire [7:0] rdata
);
  reg [1:0] sclk_s_reg;
  reg [1:0] mosi_s_reg;
  reg [1:0] cs_s_reg;
  reg sclk_d_reg;
  reg [3:0] cnt_reg;
  reg [15:0] sh_reg;
  reg [7:0] tx_reg;
  wire rise;
  wire fall;
  wire sel;

  // Two-stage synchronisers; only stage 2 is read downstream
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sclk_s_reg <= 2'h3;
      mosi_s_reg <= 2'h0;
      cs_s_reg <= 2'h3;
      sclk_d_reg <= 1'b1;
    end else begin
      sclk_s_reg <= {sclk_s_reg[0], sclk};
      mosi_s_reg <= {mosi_s_reg[0], mosi};
      cs_s_reg <= {cs_s_reg[0], cs_n};
      sclk_d_reg <= sclk_s_reg[1];
    end
  end

  assign sel = ~cs_s_reg[1];
  assign rise = sel & sclk_s_reg[1] & ~sclk_d_reg;
  assign fall = sel & ~sclk_s_reg[1] & sclk_d_reg;

  // Shift on rising edge, present read data on falling edge
  always @(posedge clk_sys) begin
    wr_stb <= 1'b0;
    if (!rst_n) begin
      cnt_reg <= 4'h0;
      sh_reg <= 16'h0000;
      tx_reg <= 8'h00;
      miso <= 1'b0;
      miso_oe_n <= 1'b1;
      addr <= 7'h00;
      wdata <= 8'h00;
    end else if (!sel) begin
      cnt_reg <= 4'h0;
      miso_oe_n <= 1'b1; // Released while deselected
    end else begin
      miso_oe_n <= 1'b0;
      if (rise) begin
        sh_reg <= {sh_reg[14:0], mosi_s_reg[1]};
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg == 4'h7) begin
          addr <= {sh_reg[5:0], mosi_s_reg[1]}; // Drop the write bit
        end
        if (cnt_reg == 4'hf) begin
          wdata <= {sh_reg[6:0], mosi_s_reg[1]};
          wr_stb <= sh_reg[14];
        end
      end
      if (fall) begin
        if (cnt_reg == 4'h8) begin
          miso <= rdata[7];
          tx_reg <= {rdata[6:0], 1'b0};
        end else begin
          miso <= tx_reg[7];
          tx_reg <= {tx_reg[6:0], 1'b0};
        end
      end
    end
  end
endmodule // lpsc_spi_slave
`default_nettype wire

// [lpsc_laser_ctrl.v]
/*
 Laser drive and eye-safety control: four serial-port registers, pulsed
 or continuous laser drive, and a latched single-fault monitor with
 periodic self-test of the drive pin.
 Assumes the analog front end reports the drive pin level as a digital
 sense input, and that an external microcontroller restores the
 registers after every reset.
*/
`timescale 1ns/100ps
`default_nettype none
`include "lpsc_defines.vh"
module lpsc_laser_ctrl (
  input wire clk_sys,
  input wire rst_n,
  input wire sclk,
  input wire mosi,
  input wire cs_n,
  output wire miso,
  output wire miso_oe_n,
  input wire laser_drive_pin,
  output reg laser_drive_on,
  output reg [1:0] current_range,
  output reg [7:0] current_level,
  output reg pin_pull_low,
  output reg laser_switch_enable_n,
  output reg laser_fault
);
  localparam ST_RUN = 2'h0;
  localparam ST_TEST = 2'h1;
  localparam ST_FAULT = 2'h2;
  // Timing limits kept as integers; cut to counter width by part-select
  localparam integer PULSE_LAST = `LPSC_PULSE_PER_CYC - 1;
  localparam integer PULSE_ON = `LPSC_PULSE_ON_CYC;
  localparam integer TEST_LAST = `LPSC_TEST_PER_CYC - 1;
  localparam integer SETTLE_LAST = `LPSC_TEST_SETTLE_CYC - 1;
  localparam integer PIN_GUARD = `LPSC_PIN_GUARD_CYC;

  reg [7:0] laser_drive_control_a_reg;
  reg [7:0] laser_current_level_reg;
  reg [7:0] laser_current_level_inverse_reg;
  reg [7:0] laser_drive_control_b_reg;
  reg [1:0] pin_s_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [15:0] test_cnt_reg;
  reg [15:0] test_cnt_next;
  reg [8:0] pulse_cnt_reg;
  reg [7:0] rdata;
  wire wr_stb;
  wire [6:0] addr;
  wire [7:0] wdata;
  wire cal_mode;
  wire pairs_ok;
  wire pin_high;
  wire drive_req;

  // Pair check: a register and its complement must differ in every bit
  function pair_ok;
    input [7:0] a;
    input [7:0] b;
    begin
      pair_ok = ((a ^ b) == 8'hff);
    end
  endfunction

  lpsc_spi_slave u_spi (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sclk(sclk),
    .mosi(mosi),
    .cs_n(cs_n),
    .miso(miso),
    .miso_oe_n(miso_oe_n),
    .wr_stb(wr_stb),
    .addr(addr),
    .wdata(wdata),
    .rdata(rdata)
  );

  // Register writes; reset puts the laser at minimum current, low range
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      laser_drive_control_a_reg <= `LPSC_RST_CTRL_A;
      laser_current_level_reg <= `LPSC_RST_LEVEL;
      laser_current_level_inverse_reg <= `LPSC_RST_LEVEL_INV;
      laser_drive_control_b_reg <= `LPSC_RST_CTRL_B;
    end else if (wr_stb) begin
      case (addr)
        `LPSC_ADDR_CTRL_A: laser_drive_control_a_reg <= wdata;
        `LPSC_ADDR_LEVEL: laser_current_level_reg <= wdata;
        `LPSC_ADDR_LEVEL_INV: laser_current_level_inverse_reg <= wdata;
        `LPSC_ADDR_CTRL_B: laser_drive_control_b_reg <= wdata;
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    case (addr)
      `LPSC_ADDR_CTRL_A: rdata = laser_drive_control_a_reg;
      `LPSC_ADDR_LEVEL: rdata = laser_current_level_reg;
      `LPSC_ADDR_LEVEL_INV: rdata = laser_current_level_inverse_reg;
      `LPSC_ADDR_CTRL_B: rdata = laser_drive_control_b_reg;
      default: rdata = 8'h00;
    endcase
  end

  // Calibration needs all three enable bits, guarding a stray write
  assign cal_mode = laser_drive_control_a_reg[`LPSC_CAL_HI:`LPSC_CAL_LO]
                    == `LPSC_CAL_ON;

  // Both pairs must be consistent before any current is applied
  assign pairs_ok = pair_ok(laser_current_level_reg,
                            laser_current_level_inverse_reg) &&
                    ({laser_drive_control_b_reg[`LPSC_RINV_HI:`LPSC_RINV_LO]}
                     == ~laser_drive_control_a_reg[`LPSC_RANGE_HI:
                                                   `LPSC_RANGE_LO]);

  // Drive pin sense from the analog side is asynchronous
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_s_reg <= 2'h3; // Healthy idle level, no false ground after reset
    end else begin
      pin_s_reg <= {pin_s_reg[0], laser_drive_pin};
    end
  end
  assign pin_high = pin_s_reg[1];

  // Pulse timer, free running; only used outside calibration
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pulse_cnt_reg <= 9'h000;
    end else if (pulse_cnt_reg == PULSE_LAST[8:0]) begin
      pulse_cnt_reg <= 9'h000;
    end else begin
      pulse_cnt_reg <= pulse_cnt_reg + 9'h001;
    end
  end

  assign drive_req = cal_mode ? 1'b1
                   : (pulse_cnt_reg < PULSE_ON[8:0]);

  // Fault monitor: run, periodic self-test, latched fault
  always @* begin
    state_next = state_reg;
    test_cnt_next = test_cnt_reg + 16'h0001;
    case (state_reg)
      ST_RUN: begin
        // Sense lags the pin by the synchroniser; a pin still recovering
        // from the self-test pull must not be taken for a ground short
        if (!pin_high && (test_cnt_reg >= PIN_GUARD[15:0])) begin
          state_next = ST_FAULT;
        end else if (test_cnt_reg == TEST_LAST[15:0]) begin
          state_next = ST_TEST;
          test_cnt_next = 16'h0000;
        end
      end
      ST_TEST: begin
        if (test_cnt_reg == SETTLE_LAST[15:0]) begin
          test_cnt_next = 16'h0000;
          // Pin must follow the internal pull; high means a supply short
          state_next = pin_high ? ST_FAULT : ST_RUN;
        end
      end
      ST_FAULT: begin
        test_cnt_next = 16'h0000;
        state_next = ST_FAULT;
      end
      default: begin
        state_next = ST_FAULT;
        test_cnt_next = 16'h0000;
      end
    endcase
  end

  // Note the ground check is blind while the pull itself holds the pin low
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
      test_cnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      test_cnt_reg <= test_cnt_next;
    end
  end

  // Registered outputs; the fault overrides drive, pull and enable until reset, not range or level
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      laser_drive_on <= 1'b0;
      current_range <= `LPSC_RANGE_LOW;
      current_level <= 8'h00;
      pin_pull_low <= 1'b0;
      laser_switch_enable_n <= 1'b0;
      laser_fault <= 1'b0;
    end else begin
      current_range <= laser_drive_control_a_reg[`LPSC_RANGE_HI:
                                                 `LPSC_RANGE_LO];
      current_level <= pairs_ok ? laser_current_level_reg : 8'h00;
      laser_drive_on <= (state_next == ST_RUN) && pairs_ok &&
                        drive_req;
      pin_pull_low <= (state_next == ST_TEST);
      laser_switch_enable_n <= (state_next != ST_RUN);
      laser_fault <= (state_next == ST_FAULT);
    end
  end
endmodule // lpsc_laser_ctrl
`default_nettype wire

// [lpsc_laser_props.sv]
/* Safety checker for the laser control block: fault, self-test, enable.
   Assumes one clock domain and binding onto lpsc_laser_ctrl. */
`timescale 1ns/100ps
`default_nettype none
module lpsc_laser_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic laser_drive_pin,
  input wire logic laser_drive_on,
  input wire logic pin_pull_low,
  input wire logic laser_switch_enable_n,
  input wire logic laser_fault
);
  logic [7:0] pull_len;
  logic [12:0] gap_len;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Lengths of each self-test and of the run between tests
  always @(posedge clk_sys) begin
    pull_len <= (!rst_n || !pin_pull_low) ? 8'h00 : pull_len + 8'h01;
    gap_len <= (!rst_n || pin_pull_low) ? 13'h0000 : gap_len + 13'h0001;
  end
  // Ground path seen long enough to clear the input synchroniser
  sequence pin_low_run_s;
    (!laser_drive_pin && !pin_pull_low) [*4];
  endsequence
  // Pin ignores the internal pull until the test ends
  sequence pin_stuck_high_s;
    (pin_pull_low && laser_drive_pin) [*8] ##1 !pin_pull_low;
  endsequence
  enable_low_a:
    assert property (!laser_fault && !pin_pull_low |-> !laser_switch_enable_n)
    else $error("enable output high in normal run");
  fault_off_a:
    assert property (laser_fault |-> laser_switch_enable_n && !laser_drive_on)
    else $error("laser not shut off during fault");
  fault_hold_a:
    assert property (laser_fault |=> laser_fault)
    else $error("fault cleared without reset");
  gnd_fault_a:
    assert property (pin_low_run_s |-> ##[0:2] laser_fault)
    else $error("ground path not flagged");
  supply_fault_a:
    assert property (pin_stuck_high_s |-> ##[0:3] laser_fault)
    else $error("pin stuck high in self-test not flagged");
  test_off_a:
    assert property (pin_pull_low |-> laser_switch_enable_n && !laser_drive_on)
    else $error("laser on during self-test");
  test_len_a:
    assert property ($fell(pin_pull_low) |-> pull_len == 8'h64)
    else $error("self-test length wrong");
  test_gap_a:
    assert property (!pin_pull_low && !laser_fault |-> gap_len <= 13'h0fa0)
    else $error("self-test not repeated in time");
endmodule // lpsc_laser_props
bind lpsc_laser_ctrl lpsc_laser_props i_props (.clk_sys(clk_sys),
  .rst_n(rst_n), .laser_drive_pin(laser_drive_pin),
  .laser_drive_on(laser_drive_on), .pin_pull_low(pin_pull_low),
  .laser_switch_enable_n(laser_switch_enable_n), .laser_fault(laser_fault));
`default_nettype wire

// [lpsc_mcu_model.sv]
/* Microcontroller model: masters the four-wire serial port.
   Assumes miso_w is the resolved wire, pulled high when not driven. */
`timescale 1ns/100ps
`default_nettype none
module lpsc_mcu_model #(
  parameter int half_cyc = 100
) (
  input wire logic clk_sys,
  input wire logic miso_w,
  output var logic sclk,
  output var logic mosi,
  output var logic cs_n
);
  // Idle bus: clock high, deselected
  initial begin
    sclk = 1'b1;
    mosi = 1'b1;
    cs_n = 1'b1;
  end
  // One 16-bit frame; half period of 100 clk keeps sclk at 1 MHz
  task automatic xfer(input logic [15:0] f, output logic [7:0] r);
    r = 8'h00;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (half_cyc) @(posedge clk_sys);
      sclk <= 1'b0;
      mosi <= f[i];
      repeat (half_cyc) @(posedge clk_sys);
      sclk <= 1'b1;
      if (i < 8) r = {r[6:0], miso_w};
    end
    repeat (half_cyc) @(posedge clk_sys);
    cs_n <= 1'b1;
    mosi <= ~mosi; // Released line shows no stale bit
  endtask
endmodule // lpsc_mcu_model
`default_nettype wire

// [tb_top.sv]
/* Testbench for the laser control block: registers, drive modes, faults.
   Assumes the microcontroller model and the bound checker are compiled. */
`timescale 1ns/100ps
`default_nettype none
`include "lpsc_defines.vh"
module tb_top;
  logic clk_sys, rst_n, short_gnd, short_sup;
  wire miso, miso_oe_n, sclk, mosi, cs_n, laser_drive_pin, laser_drive_on;
  wire pin_pull_low, laser_switch_enable_n, laser_fault;
  wire [1:0] current_range;
  wire [7:0] current_level;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  // Pull-up on miso; pin sense follows pull unless shorted
  wire miso_w = miso_oe_n ? 1'b1 : miso;
  assign laser_drive_pin = short_gnd ? 1'b0 : (short_sup | ~pin_pull_low);
  lpsc_laser_ctrl i_lpsc_laser_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
    .sclk(sclk), .mosi(mosi), .cs_n(cs_n), .miso(miso),
    .miso_oe_n(miso_oe_n), .laser_drive_pin(laser_drive_pin),
    .laser_drive_on(laser_drive_on), .current_range(current_range),
    .current_level(current_level), .pin_pull_low(pin_pull_low),
    .laser_switch_enable_n(laser_switch_enable_n), .laser_fault(laser_fault));
  lpsc_mcu_model i_lpsc_mcu_model (.clk_sys(clk_sys), .miso_w(miso_w),
    .sclk(sclk), .mosi(mosi), .cs_n(cs_n));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Cut a hang short; the full run needs about 85k cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 100000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    i_lpsc_mcu_model.xfer({1'b1, a, d}, r);
    @(negedge clk_sys);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    i_lpsc_mcu_model.xfer({1'b0, a, 8'h00}, r);
    check(r, e);
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
  endtask
  // Bounded wait for the self-test pull to reach a level
  task automatic wait_pull(input logic v);
    int n = 0;
    while (pin_pull_low !== v && n < 4200) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 4200) check(16'h0000, 16'h0001);
  endtask
  task automatic count_on(input int len, output int ones);
    ones = 0;
    repeat (len) begin
      @(negedge clk_sys);
      ones += laser_drive_on;
    end
  endtask
  task automatic t_regs();
    check(laser_switch_enable_n, 1'b0);
    check(current_range, 2'h1);
    check(current_level, 8'h00);
    rd_chk(`LPSC_ADDR_CTRL_A, `LPSC_RST_CTRL_A);
    rd_chk(`LPSC_ADDR_LEVEL, `LPSC_RST_LEVEL);
    rd_chk(`LPSC_ADDR_LEVEL_INV, `LPSC_RST_LEVEL_INV);
    rd_chk(`LPSC_ADDR_CTRL_B, `LPSC_RST_CTRL_B);
    wr(7'h20, 8'h5a);
    rd_chk(7'h20, 8'h00);
  endtask
  // Calibration drive, level stepping, then switch to the high range
  task automatic t_cal();
    int n;
    wr(`LPSC_ADDR_CTRL_B, 8'h80);
    wr(`LPSC_ADDR_CTRL_A, 8'h4e);
    wr(`LPSC_ADDR_LEVEL, 8'h00);
    wr(`LPSC_ADDR_LEVEL_INV, 8'hff);
    wait_pull(1'b1);
    wait_pull(1'b0);
    count_on(300, n);
    check(n[15:0], 16'h012c);
    wr(`LPSC_ADDR_LEVEL, 8'h01);
    check(current_level, 8'h00);
    wr(`LPSC_ADDR_LEVEL_INV, 8'hfe);
    check(current_level, 8'h01);
    wr(`LPSC_ADDR_LEVEL, 8'h00);
    wr(`LPSC_ADDR_LEVEL_INV, 8'hff);
    wr(`LPSC_ADDR_CTRL_A, 8'h8e);
    check(laser_drive_on, 1'b0);
    wr(`LPSC_ADDR_CTRL_B, 8'h40);
    check(current_range, 2'h2);
    rd_chk(`LPSC_ADDR_CTRL_B, 8'h40);
  endtask
  // Pulsed drive over two full periods, and self-test shut-off
  task automatic t_pulse();
    int n;
    wr(`LPSC_ADDR_CTRL_A, 8'h82);
    wait_pull(1'b1);
    @(negedge clk_sys);
    check(laser_switch_enable_n, 1'b1);
    check(laser_drive_on, 1'b0);
    wait_pull(1'b0);
    check(laser_switch_enable_n, 1'b0);
    count_on(800, n);
    check(n[15:0], 16'h0190);
  endtask
  // Supply short, latch, restore after reset, then ground short
  task automatic t_faults();
    @(posedge clk_sys);
    short_sup <= 1'b1;
    wait_pull(1'b1);
    wait_pull(1'b0);
    repeat (4) @(negedge clk_sys);
    check(laser_fault, 1'b1);
    check(laser_switch_enable_n, 1'b1);
    @(posedge clk_sys);
    short_sup <= 1'b0;
    repeat (200) @(negedge clk_sys);
    check(laser_fault, 1'b1);
    do_reset();
    check(laser_fault, 1'b0);
    wr(`LPSC_ADDR_CTRL_A, 8'h8e);
    wr(`LPSC_ADDR_LEVEL, 8'h01);
    wr(`LPSC_ADDR_LEVEL_INV, 8'hfe);
    wr(`LPSC_ADDR_CTRL_B, 8'h40);
    check(current_range, 2'h2);
    check(current_level, 8'h01);
    @(posedge clk_sys);
    short_gnd <= 1'b1;
    wait_pull(1'b0);
    repeat (6) @(negedge clk_sys);
    check(laser_fault, 1'b1);
    check(laser_drive_on, 1'b0);
  endtask
  initial begin
    rst_n = 1'b0;
    short_gnd = 1'b0;
    short_sup = 1'b0;
    do_reset();
    t_regs();
    t_cal();
    t_pulse();
    t_faults();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
